// ---- sif_i2c_mst.sv ----
`timescale 1ns/1ps
`default_nettype none

module sif_i2c_mst (
    input  wire logic clk,
    input  wire logic scl,
    input  wire logic sda,
    output logic      scl_low,
    output logic      sda_low
);
    // Quarter bit of 20 pclk gives a 250 kHz bus, well inside the debounce limit
    localparam int Q = 20;

    // Counts clock releases that never came back high
    int stuck = 0;

    initial begin
        scl_low = 1'b0;
        sda_low = 1'b0;
    end

    task automatic w(input int n);
        repeat (n) @(posedge clk);
    endtask

    // Release SCL and honour stretching, bounded so a stuck slave cannot hang us
    task automatic hi();
        int i;
        scl_low <= 1'b0;
        for (i = 0; i < 20000 && scl !== 1'b1; i++) @(posedge clk);
        if (scl !== 1'b1) stuck++;
        w(Q);
    endtask

    task automatic bit_io(input logic b, output logic r);
        sda_low <= !b;
        w(Q);
        hi();
        r = sda;
        w(Q);
        scl_low <= 1'b1;
        w(Q);
    endtask

    task automatic start();
        sda_low <= 1'b1;
        w(Q);
        scl_low <= 1'b1;
        w(Q);
    endtask

    task automatic stop();
        sda_low <= 1'b1;
        w(Q);
        hi();
        sda_low <= 1'b0;
        w(2 * Q);
    endtask

    // Eight bits MSB first plus the ninth clock; send 8'hff to read
    task automatic xfer(input logic [7:0] d, input logic ak, output logic [7:0] q,
                        output logic a);
        int i;
        for (i = 7; i >= 0; i--) bit_io(d[i], q[i]);
        bit_io(ak, a);
    endtask
endmodule

`default_nettype wire

// ---- sif_pkg.sv ----
// Overview of operation
// - Function field selects SPI or two-wire mode; only two-wire is built, other values idle.
// - Disabled interface releases pins, idles logic.
// - Enable rise resets flags, keeps tx-select, ack.
// - Enable rise in SPI keeps control register.
// - Slave only: slave transmit and receive.
// - Bus clock debounced for two clocks.
// - Open-drain lines, selected by address only.
// - Byte-done low while moving, set after byte.
// - Address match flag set on equal address.
// - Busy set by START, cleared by STOP.
// - Tx-select picks slave receive or transmit.
// - All bus data through shared data register.
// - Own address and SPI control share location.
// - Ack-to-send driven on ninth clock.
// - Eighth address bit captured as read request.
// - Compare address bits seven to one.
// - Record master ack; release line on nack.
package sif_pkg;
    localparam int APB_AW = 8;
    localparam int APB_DW = 32;
    localparam int DATA_W = 8;
    localparam int FIFO_DEPTH = 4;

    localparam logic [APB_AW-1:0] OFS_MODE   = 8'h00;
    localparam logic [APB_AW-1:0] OFS_STATUS = 8'h04;
    localparam logic [APB_AW-1:0] OFS_DATA   = 8'h08;
    localparam logic [APB_AW-1:0] OFS_OWN    = 8'h0c;
    localparam logic [APB_AW-1:0] OFS_TOC    = 8'h10;

    localparam int MODE_FSEL_LSB = 5;
    localparam int MODE_ON_BIT   = 1;
    localparam int ST_DONE_BIT   = 7;
    localparam int ST_MATCH_BIT  = 6;
    localparam int ST_BUSY_BIT   = 5;
    localparam int ST_TXSEL_BIT  = 4;
    localparam int ST_ACK_TO_SEND_BIT   = 3;
    localparam int ST_RW_BIT     = 2;
    localparam int ST_INTCLK_BIT = 1;
    localparam int ST_ACKRX_BIT  = 0;

    localparam logic [2:0] FSEL_RST     = 3'h7;
    localparam logic [2:0] FSEL_SPI_SLV = 3'h5;
    localparam logic [2:0] FSEL_TWI     = 3'h6;

    localparam logic       DONE_RST  = 1'h1;
    localparam logic       ACKRX_RST = 1'h1;
    localparam logic [7:0] TOC_RST   = 8'h00;
    localparam logic [7:0] OWN_RST   = 8'h00;

    localparam int SYS_CLK_HZ    = 20000000;
    localparam int DEBOUNCE_CLKS = 2;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_ADDR = 3'b001,
        ST_AACK = 3'b010,
        ST_RX   = 3'b011,
        ST_RACK = 3'b100,
        ST_TX   = 3'b101,
        ST_TACK = 3'b110
    } sif_state_t;
endpackage

// ---- sif_twi_slave.sv ----
`timescale 1ns/1ps
`default_nettype none

module sif_fifo #(
    parameter int W = 8,
    parameter int D = 4
) (
    input  wire logic         clk,
    input  wire logic         rst_n,
    input  wire logic         in_valid,
    output logic              in_ready,
    input  wire logic [W-1:0] in_data,
    output logic              out_valid,
    input  wire logic         out_ready,
    output logic      [W-1:0] out_data
);
    localparam int AW = $clog2(D);

    logic [W-1:0] mem [D];
    logic [AW-1:0] wp_reg;
    logic [AW-1:0] rp_reg;
    logic [AW:0]   cnt_reg;
    logic          push;
    logic          pop;

    assign in_ready  = (cnt_reg != (AW+1)'(D));
    assign out_valid = (cnt_reg != '0);
    assign out_data  = mem[rp_reg];
    assign push      = in_valid & in_ready;
    assign pop       = out_valid & out_ready;

    always_ff @(posedge clk) begin
        if (push) begin
            mem[wp_reg] <= in_data;
        end
    end

    // Depth is a power of two, so the pointers wrap by themselves
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wp_reg  <= '0;
            rp_reg  <= '0;
            cnt_reg <= '0;
        end else begin
            if (push) begin
                wp_reg <= wp_reg + 1'b1;
            end
            if (pop) begin
                rp_reg <= rp_reg + 1'b1;
            end
            cnt_reg <= cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
        end
    end
endmodule

module sif_twi_slave (
    input  wire logic                        pclk,
    input  wire logic                        presetn,
    input  wire logic                        psel,
    input  wire logic                        penable,
    input  wire logic                        pwrite,
    input  wire logic [sif_pkg::APB_AW-1:0] paddr,
    input  wire logic [sif_pkg::APB_DW-1:0] pwdata,
    output logic      [sif_pkg::APB_DW-1:0] prdata,
    output logic                             pready,
    output logic                             pslverr,
    input  wire logic                        scl_i,
    output logic                             scl_o,
    output logic                             scl_oe,
    input  wire logic                        sda_i,
    output logic                             sda_o,
    output logic                             sda_oe,
    output logic                             pins_owned
);
    import sif_pkg::*;

    logic [1:0]  sy0_reg;
    logic [1:0]  sy1_reg;
    logic [1:0]  line_s;
    logic [1:0]  line_db;
    logic        scl_s;
    logic        scl_db;
    logic        sda_db;
    logic        scl_prev_reg;
    logic        sda_prev_reg;
    logic        rise;
    logic        fall;
    logic        start;
    logic        stop;

    logic [2:0]  fsel_reg;
    logic        on_reg;
    logic        on_prev_reg;
    logic        on_rise;
    logic        twi_act;
    logic        eng_ok;
    logic        done_reg;
    logic        match_reg;
    logic        busy_reg;
    logic        txsel_reg;
    logic        ack_to_send_reg;
    logic        rw_reg;
    logic        intclk_reg;
    logic        ackrx_reg;
    logic [7:0]  data_reg;
    logic        rxfull_reg;
    logic [7:1]  own_reg;
    logic [7:0]  toc_reg;

    sif_state_t  st_reg;
    logic [3:0]  cnt_reg;
    logic        ph_reg;
    logic        pend_reg;
    logic [7:0]  txb_reg;
    logic [7:0]  rxsh_reg;
    logic        sda_oe_reg;
    logic        scl_oe_reg;

    logic        setup;
    logic        wr;
    logic        rd_data;
    logic        mapped;
    logic [7:0]  rdata;
    logic        pready_reg;
    logic        pslverr_reg;
    logic [APB_DW-1:0] prdata_reg;
    logic        pins_owned_reg;

    logic        fifo_in_valid;
    logic        fifo_in_ready;
    logic        fifo_out_valid;
    logic [7:0]  fifo_out_data;
    logic        fifo_pop;

    // Both lines get the same synchroniser and filter so START/STOP ordering survives
    assign line_s = {sy1_reg[1], sy0_reg[1]};
    assign scl_s  = line_s[0];
    assign scl_db = line_db[0];
    assign sda_db = line_db[1];

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sy0_reg <= 2'h3;
            sy1_reg <= 2'h3;
        end else begin
            sy0_reg <= {sy0_reg[0], scl_i};
            sy1_reg <= {sy1_reg[0], sda_i};
        end
    end

    genvar gi;
    generate
        for (gi = 0; gi < 2; gi++) begin : g_deb
            logic cnt_q;
            logic db_q;
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    cnt_q <= 1'b0;
                    db_q  <= 1'b1;
                end else if (line_s[gi] != db_q) begin
                    if (cnt_q == 1'(DEBOUNCE_CLKS - 1)) begin
                        db_q  <= line_s[gi];
                        cnt_q <= 1'b0;
                    end else begin
                        cnt_q <= cnt_q + 1'b1;
                    end
                end else begin
                    cnt_q <= 1'b0;
                end
            end
            assign line_db[gi] = db_q;
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scl_prev_reg <= 1'b1;
            sda_prev_reg <= 1'b1;
            on_prev_reg  <= 1'b0;
        end else begin
            scl_prev_reg <= scl_db;
            sda_prev_reg <= sda_db;
            on_prev_reg  <= on_reg;
        end
    end

    assign rise    = scl_db & ~scl_prev_reg;
    assign fall    = ~scl_db & scl_prev_reg;
    assign start   = scl_db & scl_prev_reg & sda_prev_reg & ~sda_db;
    assign stop    = scl_db & scl_prev_reg & ~sda_prev_reg & sda_db;
    assign twi_act = on_reg & (fsel_reg == FSEL_TWI);
    assign on_rise = on_reg & ~on_prev_reg;
    assign eng_ok  = twi_act & ~on_rise & ~start & ~stop;

    // APB: no wait state, yet prdata and pready both leave flip-flops
    assign setup   = psel & ~penable;
    assign wr      = psel & penable & pready_reg & pwrite;
    assign rd_data = psel & penable & pready_reg & ~pwrite & (paddr == OFS_DATA);
    assign mapped  = (paddr == OFS_MODE) | (paddr == OFS_STATUS) | (paddr == OFS_DATA)
                   | (paddr == OFS_OWN) | (paddr == OFS_TOC);

    always_comb begin
        case (paddr)
            OFS_MODE:   rdata = {fsel_reg, 3'h0, on_reg, 1'h0};
            OFS_STATUS: rdata = {done_reg, match_reg, busy_reg, txsel_reg,
                                 ack_to_send_reg, rw_reg, intclk_reg, ackrx_reg};
            OFS_DATA:   rdata = data_reg;
            OFS_OWN:    rdata = {own_reg, 1'h0};
            OFS_TOC:    rdata = toc_reg;
            default:    rdata = 8'h00;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
            prdata_reg  <= '0;
        end else begin
            pready_reg  <= setup;
            pslverr_reg <= setup & ~mapped;
            if (setup & ~pwrite) begin
                prdata_reg <= {{(APB_DW-8){1'b0}}, rdata};
            end
        end
    end

    // Control bits survive an enable edge: software must set them beforehand
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fsel_reg   <= FSEL_RST;
            on_reg     <= 1'b0;
            txsel_reg  <= 1'b0;
            ack_to_send_reg   <= 1'b0;
            intclk_reg <= 1'b0;
            own_reg    <= OWN_RST[7:1];
            toc_reg    <= TOC_RST;
        end else if (wr) begin
            case (paddr)
                OFS_MODE: begin
                    fsel_reg <= pwdata[MODE_FSEL_LSB +: 3];
                    on_reg   <= pwdata[MODE_ON_BIT];
                end
                OFS_STATUS: begin
                    txsel_reg  <= pwdata[ST_TXSEL_BIT];
                    ack_to_send_reg   <= pwdata[ST_ACK_TO_SEND_BIT];
                    intclk_reg <= pwdata[ST_INTCLK_BIT];
                end
                OFS_OWN: begin
                    own_reg <= pwdata[7:1];
                end
                OFS_TOC: begin
                    toc_reg <= pwdata[7:0];
                end
                default: begin
                end
            endcase
        end
    end

    // Receive FIFO feeds the shared data register once software has read it
    assign fifo_pop = fifo_out_valid & ~rxfull_reg;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            data_reg   <= 8'h00;
            rxfull_reg <= 1'b0;
        end else begin
            if (wr && paddr == OFS_DATA) begin
                data_reg <= pwdata[7:0];
            end
            if (rd_data) begin
                rxfull_reg <= 1'b0;
            end
            if (fifo_pop) begin
                data_reg   <= fifo_out_data;
                rxfull_reg <= 1'b1;
            end
        end
    end

    assign fifo_in_valid = (st_reg == ST_RACK) & ~ph_reg & (pend_reg | fall) & eng_ok;

    sif_fifo #(
        .W (DATA_W),
        .D (FIFO_DEPTH)
    ) u_rx_fifo (
        .clk       (pclk),
        .rst_n     (presetn),
        .in_valid  (fifo_in_valid),
        .in_ready  (fifo_in_ready),
        .in_data   (rxsh_reg),
        .out_valid (fifo_out_valid),
        .out_ready (~rxfull_reg),
        .out_data  (fifo_out_data)
    );

    // Slave-only engine: never drives START, STOP or clock edges of its own
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            st_reg     <= ST_IDLE;
            cnt_reg    <= 4'h0;
            ph_reg     <= 1'b0;
            pend_reg   <= 1'b0;
            txb_reg    <= 8'h00;
            rxsh_reg   <= 8'h00;
            sda_oe_reg <= 1'b0;
            scl_oe_reg <= 1'b0;
            done_reg   <= DONE_RST;
            match_reg  <= 1'b0;
            busy_reg   <= 1'b0;
            rw_reg     <= 1'b0;
            ackrx_reg  <= ACKRX_RST;
        end else if (!twi_act || on_rise || start || stop) begin
            st_reg     <= start && twi_act && !on_rise ? ST_ADDR : ST_IDLE;
            cnt_reg    <= 4'h0;
            ph_reg     <= 1'b0;
            pend_reg   <= 1'b0;
            sda_oe_reg <= 1'b0;
            scl_oe_reg <= 1'b0;
            if (twi_act && on_rise) begin
                done_reg  <= DONE_RST;
                match_reg <= 1'b0;
                busy_reg  <= 1'b0;
                rw_reg    <= 1'b0;
                ackrx_reg <= ACKRX_RST;
            end else if (twi_act && start) begin
                busy_reg  <= 1'b1;
                match_reg <= 1'b0;
                done_reg  <= 1'b0;
            end else if (twi_act && stop) begin
                busy_reg <= 1'b0;
            end
        end else begin
            case (st_reg)
                ST_ADDR: begin
                    if (rise) begin
                        rxsh_reg <= {rxsh_reg[6:0], sda_db};
                        cnt_reg  <= cnt_reg + 4'h1;
                        if (cnt_reg == 4'h7) begin
                            if (rxsh_reg[6:0] == own_reg) begin
                                match_reg <= 1'b1;
                                rw_reg    <= sda_db;
                                done_reg  <= 1'b1;
                                st_reg    <= ST_AACK;
                                ph_reg    <= 1'b0;
                            end else begin
                                st_reg <= ST_IDLE;
                            end
                        end
                    end
                end
                ST_AACK: begin
                    if (fall && !ph_reg) begin
                        sda_oe_reg <= 1'b1;
                        ph_reg     <= 1'b1;
                    end else if (fall) begin
                        ph_reg   <= 1'b0;
                        cnt_reg  <= 4'h0;
                        done_reg <= 1'b0;
                        if (txsel_reg) begin
                            txb_reg    <= data_reg;
                            sda_oe_reg <= ~data_reg[7];
                            st_reg     <= ST_TX;
                        end else begin
                            sda_oe_reg <= 1'b0;
                            st_reg     <= ST_RX;
                        end
                    end
                end
                ST_RX: begin
                    if (rise) begin
                        rxsh_reg <= {rxsh_reg[6:0], sda_db};
                        cnt_reg  <= cnt_reg + 4'h1;
                        if (cnt_reg == 4'h7) begin
                            done_reg <= 1'b1;
                            st_reg   <= ST_RACK;
                            ph_reg   <= 1'b0;
                        end
                    end
                end
                ST_RACK: begin
                    if (!ph_reg && (pend_reg || fall)) begin
                        // A full FIFO holds the clock low until space frees up
                        if (fifo_in_ready) begin
                            sda_oe_reg <= ~ack_to_send_reg;
                            scl_oe_reg <= 1'b0;
                            pend_reg   <= 1'b0;
                            ph_reg     <= 1'b1;
                        end else begin
                            pend_reg   <= 1'b1;
                            scl_oe_reg <= 1'b1;
                        end
                    end else if (ph_reg && fall) begin
                        sda_oe_reg <= 1'b0;
                        ph_reg     <= 1'b0;
                        cnt_reg    <= 4'h0;
                        done_reg   <= 1'b0;
                        st_reg     <= ST_RX;
                    end
                end
                ST_TX: begin
                    if (rise) begin
                        cnt_reg <= cnt_reg + 4'h1;
                    end else if (fall) begin
                        if (cnt_reg == 4'h8) begin
                            sda_oe_reg <= 1'b0;
                            done_reg   <= 1'b1;
                            ph_reg     <= 1'b0;
                            st_reg     <= ST_TACK;
                        end else begin
                            sda_oe_reg <= ~txb_reg[3'h7 - cnt_reg[2:0]];
                        end
                    end
                end
                ST_TACK: begin
                    if (rise) begin
                        ackrx_reg <= sda_db;
                        if (sda_db) begin
                            st_reg <= ST_IDLE;
                        end else begin
                            ph_reg <= 1'b1;
                        end
                    end else if (fall && ph_reg) begin
                        txb_reg    <= data_reg;
                        sda_oe_reg <= ~data_reg[7];
                        cnt_reg    <= 4'h0;
                        done_reg   <= 1'b0;
                        ph_reg     <= 1'b0;
                        st_reg     <= ST_TX;
                    end
                end
                default: begin
                    st_reg <= ST_IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pins_owned_reg <= 1'b0;
        end else begin
            pins_owned_reg <= twi_act;
        end
    end

    assign prdata     = prdata_reg;
    assign pready     = pready_reg;
    assign pslverr    = pslverr_reg;
    assign sda_oe     = sda_oe_reg;
    assign scl_oe     = scl_oe_reg;
    // Open drain: both bus pins, SDA and SCL, only ever pull low
    assign sda_o      = 1'b0;
    assign scl_o      = 1'b0;
    assign pins_owned = pins_owned_reg;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    a_flag_defaults: assert property (twi_act && on_rise |=>
        done_reg && !match_reg && !busy_reg && !rw_reg && ackrx_reg)
        else $error("flags not defaulted on enable");
    a_off_release: assert property (!on_reg |=>
        !pins_owned_reg && !sda_oe_reg && !scl_oe_reg)
        else $error("pins held while disabled");
    a_busy_start: assert property (twi_act && !on_rise && start |=>
        busy_reg && st_reg == ST_ADDR)
        else $error("start not seen");
    a_busy_stop: assert property (twi_act && !on_rise && stop |=> !busy_reg)
        else $error("stop not seen");
    a_addr_match: assert property (eng_ok && st_reg == ST_ADDR && rise && cnt_reg == 4'h7
        && rxsh_reg[6:0] == own_reg |=> match_reg && st_reg == ST_AACK && done_reg)
        else $error("address match missed");
    a_rw_capture: assert property (eng_ok && st_reg == ST_ADDR && rise && cnt_reg == 4'h7
        && rxsh_reg[6:0] == own_reg |=> rw_reg == $past(sda_db))
        else $error("read request not captured");
    a_done_moving: assert property (st_reg == ST_RX || st_reg == ST_TX |-> !done_reg)
        else $error("done flag high mid byte");
    a_ack_drive: assert property (fifo_in_valid && fifo_in_ready |=>
        ph_reg && sda_oe_reg == !$past(ack_to_send_reg))
        else $error("ack bit not driven");
    a_nack_release: assert property (eng_ok && st_reg == ST_TACK && rise && sda_db |=>
        !sda_oe_reg && ackrx_reg && st_reg == ST_IDLE)
        else $error("line held after nack");
    a_stretch_full: assert property (fifo_in_valid && !fifo_in_ready && !fifo_pop |=>
        scl_oe_reg [*2])
        else $error("clock not stretched");
    a_deb_stable: assert property (scl_db != scl_prev_reg |->
        $past(scl_s, 1) == scl_db && $past(scl_s, 2) == scl_db)
        else $error("clock filter too short");
endmodule

`default_nettype wire

// ---- tb_top.sv ----
`timescale 1ns/1ps
`default_nettype none

module tb_top;
    import sif_pkg::*;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready, pslverr, scl_oe, sda_oe, pins_owned, m_scl, m_sda, a;
    logic        scl_out, sda_out;
    logic        st_seen = 1'b0;
    logic [7:0]  q, dt;
    logic [7:0]  db [6];
    logic [16:0] exp_q [$];
    int          err_count = 0;
    int          tests_run = 0;
    wire         scl_w = !(scl_oe | m_scl);
    wire         sda_w = !(sda_oe | m_sda);

    always #25 pclk = ~pclk;

    sif_twi_slave u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .scl_i(scl_w), .scl_o(scl_out), .scl_oe(scl_oe), .sda_i(sda_w),
        .sda_o(sda_out), .sda_oe(sda_oe), .pins_owned(pins_owned));

    sif_i2c_mst u_mst (.clk(pclk), .scl(scl_w), .sda(sda_w), .scl_low(m_scl),
        .sda_low(m_sda));

    task automatic chk(input string n, input logic [32:0] e, input logic [32:0] g);
        tests_run++;
        if (g !== e) begin
            $display("Error %s expected %h seen %h", n, e, g);
            err_count++;
        end
    endtask

    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", tests_run, err_count);
        if (err_count == 0 && tests_run > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask

    task automatic apb(input logic wr, input logic [7:0] ad, input logic [7:0] d,
                       input logic [16:0] e);
        int i;
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= ad;
        pwdata <= {24'($urandom), d};
        if (!wr) exp_q.push_back(e);
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 50; i++) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
        end
        if (i == 50) chk("pready", 1, 0);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask

    task automatic wr(input logic [7:0] ad, input logic [7:0] d);
        apb(1'b1, ad, d, 17'h0);
    endtask

    task automatic rd(input logic [7:0] ad, input logic [7:0] d, input logic [7:0] m,
                      input logic er = 1'b0);
        apb(1'b0, ad, 8'h00, {er, m, d});
    endtask

    // Watches read answers and retires the oldest expectation
    always @(posedge pclk) begin
        logic [16:0] e;
        if (scl_oe === 1'b1) st_seen <= 1'b1;
        if (psel && penable && pready === 1'b1 && !pwrite) begin
            e = (exp_q.size() > 0) ? exp_q.pop_front() : 17'h1ffff;
            chk("prdata", {e[16], 24'h0, e[7:0] & e[15:8]},
                {pslverr, prdata[31:8], prdata[7:0] & e[15:8]});
        end
    end

    initial begin
        repeat (60000) @(posedge pclk);
        err_count++;
        print_verdict();
    end

    initial begin
        void'($urandom(57));
        foreach (db[i]) db[i] = 8'($urandom);
        dt = 8'($urandom);
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        rd(OFS_MODE, 8'he0, 8'hff);
        rd(OFS_STATUS, 8'h81, 8'hff);
        rd(8'h14, 8'h00, 8'hff, 1'b1);
        wr(OFS_OWN, 8'hb5);
        rd(OFS_OWN, 8'hb4, 8'hff);
        wr(OFS_MODE, 8'hc2);
        repeat (2) @(posedge pclk);
        chk("pins_owned", 1, pins_owned);
        rd(OFS_STATUS, 8'h81, 8'hff);
        $display("Test config done");
        // Six bytes against one data word plus four FIFO slots forces a stretch
        fork
            begin
                u_mst.start();
                u_mst.xfer(8'hb4, 1'b1, q, a);
                chk("addr ack", 0, a);
                foreach (db[i]) begin
                    u_mst.xfer(db[i], 1'b1, q, a);
                    chk("data ack", 0, a);
                end
                u_mst.stop();
            end
            begin
                repeat (1000) @(posedge pclk);
                rd(OFS_STATUS, 8'h60, 8'h64);
                repeat (5000) @(posedge pclk);
                foreach (db[i]) begin
                    rd(OFS_DATA, db[i], 8'hff);
                    repeat (10) @(posedge pclk);
                end
            end
        join
        chk("stretch", 1, st_seen);
        rd(OFS_STATUS, 8'h00, 8'h20);
        $display("Test receive done");
        u_mst.start();
        u_mst.xfer(8'h22, 1'b1, q, a);
        chk("foreign ack", 1, a);
        u_mst.stop();
        wr(OFS_STATUS, 8'h10);
        wr(OFS_DATA, dt);
        u_mst.start();
        u_mst.xfer(8'hb5, 1'b1, q, a);
        chk("read ack", 0, a);
        u_mst.xfer(8'hff, 1'b1, q, a);
        chk("tx byte", dt, q);
        u_mst.stop();
        chk("sda released", 0, sda_oe);
        rd(OFS_STATUS, 8'h15, 8'h15);
        $display("Test transmit done");
        wr(OFS_MODE, 8'hc0);
        wr(OFS_STATUS, 8'h1a);
        wr(OFS_MODE, 8'hc2);
        rd(OFS_STATUS, 8'h9b, 8'hff);
        for (int f = 0; f < 8; f++) begin
            wr(OFS_MODE, {3'(f), 5'h02});
            repeat (2) @(posedge pclk);
            chk("pins_owned", (f == 6), pins_owned);
        end
        wr(OFS_MODE, 8'h00);
        wr(OFS_MODE, 8'h02);
        rd(OFS_OWN, 8'hb4, 8'hff);
        wr(OFS_TOC, dt);
        rd(OFS_TOC, dt, 8'hff);
        chk("open drain", 0, {scl_out, sda_out});
        chk("scl stuck", 0, u_mst.stuck);
        $display("Test modes done");
        print_verdict();
    end
endmodule

`default_nettype wire
